/* File: bench/rdc_ctrl_bench.sv */
// Self-checking bench for the redistributor control block
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Bench top
// ----------------------------------------
module rdc_ctrl_bench;
    import rdc_pkg::*;
    logic        clk_sys = 1'b0, resetn = 1'b0, reg_valid = 1'b0, reg_ack;
    rdc_req_t    reg_req = '0;
    rdc_sel_in_t sel_in = 5'h1c;
    logic        single_security_state_setting = 1'b0, select_disable_capability = 1'b1;
    logic        affinity_ns_enable = 1'b1, affinity_s_enable = 1'b1, upstream_busy = 1'b0;
    logic        private_enable_clear_write = 1'b0, propagate_done = 1'b0;
    logic        msg_query_pending, msg_clear_valid, message_interrupt_enable, pending_table_load;
    logic [31:0] reg_rdata, private_active, private_deactivate, act_set = '0;
    logic [31:0] private_secure_mask = 32'h0000ffff;
    logic [15:0] msg_query_id, msg_clear_id;
    logic [2:0]  selectable, retarget_req;
    int          fails = 0, tests_run = 0, cyc = 0;
    rdc_ctrl uut (.clk_sys, .resetn, .reg_valid, .reg_req, .reg_ack, .reg_rdata,
        .single_security_state_setting, .select_disable_capability, .affinity_ns_enable,
        .affinity_s_enable, .private_secure_mask, .upstream_busy, .private_enable_clear_write,
        .propagate_done, .msg_query_id, .msg_query_pending, .msg_clear_valid, .msg_clear_id,
        .message_interrupt_enable, .pending_table_load, .private_active, .private_deactivate,
        .sel_in, .selectable, .retarget_req);
    rdc_far_model far (.clk_sys, .resetn, .msg_query_id, .msg_query_pending, .msg_clear_valid,
        .msg_clear_id, .act_set, .private_deactivate, .private_active);
    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic close_out;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            close_out;
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One access; outputs of the answer cycle are still standing on return
    task automatic acc(input logic w, s, input logic [16:0] a, input logic [63:0] d,
        input logic s64 = 1'b0);
        @(posedge clk_sys);
        reg_valid <= 1'b1;
        reg_req <= '{w, s, s64, a, d};
        @(posedge clk_sys);
        reg_valid <= 1'b0;
        #1;
        chk(reg_ack, 1'b1);
    endtask : acc
    task automatic t_reset;
        @(posedge clk_sys) upstream_busy <= 1'b1;
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h80000000);
        @(posedge clk_sys) upstream_busy <= 1'b0;
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h0);
        acc(1'b0, 1'b1, 17'h48, '0);
        chk(reg_rdata, 32'h0);
        acc(1'b1, 1'b1, 17'h48, 64'h2000);
        chk(msg_clear_valid, 1'b0);
    endtask : t_reset
    task automatic t_ctrl;
        acc(1'b1, 1'b1, 17'h0, 64'hffffffff);
        chk(retarget_req, 3'h7);
        chk(pending_table_load, 1'b1);
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h07000009);
        chk(selectable, 3'h0);
        @(posedge clk_sys) propagate_done <= 1'b1;
        @(posedge clk_sys) propagate_done <= 1'b0;
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h07000001);
        @(posedge clk_sys) private_enable_clear_write <= 1'b1;
        @(posedge clk_sys) private_enable_clear_write <= 1'b0;
        acc(1'b1, 1'b0, 17'h0, '0);
        chk(retarget_req, 3'h2);
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h05000009);
        acc(1'b1, 1'b1, 17'h0, '0);
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata, 32'h00000009);
        chk(selectable, 3'h7);
        @(posedge clk_sys) sel_in <= 5'h1f;
        #1 chk(selectable, 3'h0);
        @(posedge clk_sys) single_security_state_setting <= 1'b1;
        acc(1'b1, 1'b1, 17'h0, 64'h07000000);
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata[26:24], 3'h3);
        @(posedge clk_sys) select_disable_capability <= 1'b0;
        acc(1'b0, 1'b1, 17'h0, '0);
        chk(reg_rdata[26:24], 3'h0);
        @(posedge clk_sys) affinity_ns_enable <= 1'b0;
        #1 chk(message_interrupt_enable, 1'b0);
        @(posedge clk_sys) affinity_ns_enable <= 1'b1;
        select_disable_capability <= 1'b1;
        single_security_state_setting <= 1'b0;
        sel_in <= 5'h1c;
        acc(1'b1, 1'b1, 17'h0, 64'h1);
        chk(pending_table_load, 1'b0);
        chk(retarget_req, 3'h3);
    endtask : t_ctrl
    task automatic t_msg;
        acc(1'b1, 1'b0, 17'h48, 64'hdeadbeef00002003);
        chk(msg_clear_valid, 1'b1);
        chk(msg_clear_id, 16'h2003);
        acc(1'b1, 1'b0, 17'h48, 64'h2003);
        chk(msg_clear_valid, 1'b0);
        acc(1'b1, 1'b0, 17'h48, 64'h100002004, 1'b1);
        chk(msg_clear_valid, 1'b0);
        acc(1'b1, 1'b0, 17'h4c, 64'h2004);
        chk(msg_clear_valid, 1'b0);
        acc(1'b1, 1'b0, 17'h48, 64'h2004, 1'b1);
        chk(msg_clear_valid, 1'b1);
        acc(1'b1, 1'b0, 17'h48, 64'h1fff);
        chk(msg_clear_valid, 1'b0);
    endtask : t_msg
    task automatic t_active;
        @(posedge clk_sys) act_set <= 32'hffffffff;
        @(posedge clk_sys) act_set <= '0;
        acc(1'b0, 1'b0, 17'h10380, '0);
        chk(reg_rdata, 32'hffff0000);
        acc(1'b1, 1'b0, 17'h10380, 64'hffffffff);
        chk(private_deactivate, 32'hffff0000);
        acc(1'b0, 1'b1, 17'h10380, '0);
        chk(reg_rdata, 32'h0000ffff);
        acc(1'b1, 1'b1, 17'h10380, '0);
        chk(private_deactivate, 32'h0);
        @(posedge clk_sys) affinity_s_enable <= 1'b0;
        acc(1'b0, 1'b1, 17'h10380, '0);
        chk(reg_rdata, 32'h0);
        @(posedge clk_sys) affinity_s_enable <= 1'b1;
        acc(1'b1, 1'b1, 17'h10380, 64'h0101);
        chk(private_deactivate, 32'h0101);
    endtask : t_active
    initial
    begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset;
        t_ctrl;
        t_msg;
        t_active;
        close_out;
    end
endmodule : rdc_ctrl_bench
`default_nettype wire

/* File: bench/rdc_ctrl_sva.sv */
// Port checker for the redistributor control block
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module rdc_ctrl_sva
(
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              resetn,
    // Register access and status
    input wire logic              reg_valid,
    input wire rdc_pkg::rdc_req_t reg_req,
    input wire logic [31:0]       reg_rdata,
    input wire logic              upstream_busy,
    input wire logic              affinity_ns_enable,
    // Message interrupt side
    input wire logic              msg_query_pending,
    input wire logic              msg_clear_valid,
    input wire logic [15:0]       msg_clear_id,
    input wire logic              message_interrupt_enable,
    input wire logic              pending_table_load,
    // Private and selection side
    input wire logic [31:0]       private_deactivate,
    input wire rdc_pkg::rdc_sel_in_t sel_in,
    input wire logic [2:0]        selectable,
    input wire logic [2:0]        retarget_req
);
    import rdc_pkg::*;
    logic wr, rd0, clr, ok;
    assign wr = reg_valid && reg_req.write;
    assign rd0 = reg_valid && !reg_req.write && reg_req.addr == 17'h0;
    assign clr = wr && reg_req.addr == 17'h48;
    // Upper bits must be zero, a 32-bit write only brings the low half
    assign ok = (reg_req.size64 ? reg_req.wdata[63:16] == '0 : reg_req.wdata[31:16] == '0)
        && reg_req.wdata[15:0] >= 16'h2000 && message_interrupt_enable && msg_query_pending;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_RSV_ZERO: assert property (rd0 |=> (reg_rdata & 32'h78fffff6) == '0)
        else $error("reserved control bits not zero");
    AST_UWP: assert property (rd0 ##1 $stable(upstream_busy) |-> reg_rdata[31] == upstream_busy)
        else $error("upstream pending flag wrong");
    AST_MSG_CLEAR: assert property (clr && ok |=> msg_clear_valid && msg_clear_id == $past(reg_req.wdata[15:0]))
        else $error("pending clear not issued");
    AST_MSG_IGNORE: assert property (clr && !ok |=> !msg_clear_valid)
        else $error("pending clear not ignored");
    AST_MSG_CAUSE: assert property (msg_clear_valid |-> $past(clr))
        else $error("pending clear without write");
    AST_EN_STICKY: assert property (message_interrupt_enable |=> message_interrupt_enable || !affinity_ns_enable)
        else $error("enable fell");
    AST_EN_RES0: assert property (!affinity_ns_enable |-> !message_interrupt_enable)
        else $error("enable visible without routing");
    AST_LOAD: assert property (pending_table_load |-> message_interrupt_enable ##1 !pending_table_load)
        else $error("table load pulse wrong");
    AST_SELECT: assert property ((selectable & ~(sel_in.grp_enable & {3{!sel_in.processor_sleep_flag}})) == '0)
        else $error("selectable when not allowed");
    AST_RETARGET: assert property (retarget_req != '0 |-> $past(wr && reg_req.addr == 17'h0))
        else $error("retarget without control write");
    AST_DEACT: assert property (private_deactivate != '0 |-> $past(wr && reg_req.addr == 17'h10380))
        else $error("deactivate without write");
endmodule : rdc_ctrl_sva
bind rdc_ctrl rdc_ctrl_sva chk (.clk_sys, .resetn, .reg_valid, .reg_req, .reg_rdata,
    .upstream_busy, .affinity_ns_enable, .msg_query_pending, .msg_clear_valid, .msg_clear_id,
    .message_interrupt_enable, .pending_table_load, .private_deactivate, .sel_in,
    .selectable, .retarget_req);
`default_nettype wire

/* File: bench/rdc_far_model.sv */
// Far side model: message pending table and private active state
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Distributor and processor side
// ----------------------------------------
module rdc_far_model
#(
    parameter logic [15:0] PEND_INIT = 16'h00ff
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Message interrupt side
    input  wire logic [15:0] msg_query_id,
    output logic             msg_query_pending,
    input  wire logic        msg_clear_valid,
    input  wire logic [15:0] msg_clear_id,
    // Private active state
    input  wire logic [31:0] act_set,
    input  wire logic [31:0] private_deactivate,
    output logic [31:0]      private_active
);
    // Only ids 0x2000 to 0x200f are tracked, others never pending
    logic [15:0] pend_r;
    logic [31:0] act_r;
    assign msg_query_pending = msg_query_id[15:4] == 12'h200 && pend_r[msg_query_id[3:0]];
    assign private_active = act_r;
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            pend_r <= PEND_INIT;
        else if (msg_clear_valid && msg_clear_id[15:4] == 12'h200)
            pend_r[msg_clear_id[3:0]] <= 1'b0;
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            act_r <= 32'h0;
        else
            act_r <= (act_r | act_set) & ~private_deactivate;
endmodule : rdc_far_model
`default_nettype wire

/* File: verilog/rdc_ctrl.sv */
// Redistributor control, message pending clear and private active clear logic
`timescale 1ns/100ps
`default_nettype none
`include "rdc_defs.svh"

// How it works
// - Pending clear write-only, 32-bit writes zero-extended
// - Pending clear write clears named message interrupt
// - Ignore clear if disabled, unimplemented, not pending
// - 64-bit clear register, unimplemented identifier bits zero
// - Bit 31 shows upstream writes still outstanding
// - Bit 26 blocks secure group 1 selection
// - Bit 26 zero if single state; secure only
// - Bit 25 blocks non-secure group 1 selection
// - Bit 24 blocks group 0; non-secure writes ignored unless single state
// - Select-disable bits zero without capability; reset 0
// - Bit 3 shows enable-clear/select writes propagating
// - Enable bit 0 off disables message interrupts
// - Enable sticks once set; triggers pending table load
// - Enable reads zero without non-secure affinity routing
// - Selectable only awake, not disabled, group enabled
// - Asleep never selected, even with wake-on-group1 set
// - Select-disable change requests retargeting of forwarded interrupt
// - Active clear: bits 15:0 software, 31:16 private
// - Active clear zero without affinity routing for state
// - Secure private bits hidden from non-secure accesses
// - Read shows active; writing 1 deactivates
module rdc_ctrl
(
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    // Register access
    input  wire logic                  reg_valid,
    input  wire rdc_pkg::rdc_req_t     reg_req,
    output logic                       reg_ack,
    output logic [31:0]                reg_rdata,
    // Configuration straps
    input  wire logic                  single_security_state_setting,
    input  wire logic                  select_disable_capability,
    input  wire logic                  affinity_ns_enable,
    input  wire logic                  affinity_s_enable,
    input  wire logic [31:0]           private_secure_mask,
    // Upstream and propagation status
    input  wire logic                  upstream_busy,
    input  wire logic                  private_enable_clear_write,
    input  wire logic                  propagate_done,
    // Message interrupt side
    output logic [15:0]                msg_query_id,
    input  wire logic                  msg_query_pending,
    output logic                       msg_clear_valid,
    output logic [15:0]                msg_clear_id,
    output logic                       message_interrupt_enable,
    output logic                       pending_table_load,
    // Private interrupt active state
    input  wire logic [31:0]           private_active,
    output logic [31:0]                private_deactivate,
    // One-of-N selection
    input  wire rdc_pkg::rdc_sel_in_t  sel_in,
    output logic [2:0]                 selectable,
    output logic [2:0]                 retarget_req
);
    import rdc_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic        wr_ctrl;
    logic        wr_clear;
    logic        wr_active;
    logic [63:0] clear_val;
    logic [31:0] active_view;
    logic [2:0]  dpg_wmask;
    logic [2:0]  dpg_new;
    logic [2:0]  dpg_vis;
    logic        msg_en_vis;

    logic [2:0]  dpg_r;
    logic        msg_en_r;
    logic        rwp_r;

    assign wr_ctrl   = reg_valid && reg_req.write && reg_req.addr == `RDC_OFF_CONTROL;
    assign wr_clear  = reg_valid && reg_req.write && reg_req.addr == `RDC_OFF_MSG_CLEAR;
    assign wr_active = reg_valid && reg_req.write && reg_req.addr == `RDC_OFF_ACTIVE_CLEAR;

    // Narrow writes carry nothing above bit 31
    assign clear_val = reg_req.size64 ? reg_req.wdata
                                      : {32'h00000000, reg_req.wdata[31:0]};
    assign msg_query_id = clear_val[`RDC_ID_BITS-1:0];

    // ----------------------------------------------------------------
    // Access rights for the select-disable bits
    // ----------------------------------------------------------------
    always_comb
    begin
        dpg_wmask = {3{select_disable_capability}};
        if (single_security_state_setting)
        begin
            dpg_wmask[2] = 1'b0;
        end
        else if (!reg_req.secure)
        begin
            dpg_wmask[2] = 1'b0;
            dpg_wmask[0] = 1'b0;
        end
    end

    assign dpg_new = {reg_req.wdata[`RDC_BIT_SECURE_GRP1_SELECT_DISABLE],
                      reg_req.wdata[`RDC_BIT_NONSECURE_GRP1_SELECT_DISABLE],
                      reg_req.wdata[`RDC_BIT_GRP0_SELECT_DISABLE]};

    // Bits hidden by a strap act as zero for reads and for selection alike
    assign dpg_vis = dpg_r & {!single_security_state_setting, 1'b1, 1'b1}
                     & {3{select_disable_capability}};

    // ----------------------------------------------------------------
    // Select-disable bits
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dpg_r <= `RDC_CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            dpg_r <= (dpg_r & ~dpg_wmask) | (dpg_new & dpg_wmask);
        end
    end

    // A change hands any forwarded interrupt of that group back to routing;
    // the routing side drops the request for an interrupt already active.
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            retarget_req <= 3'h0;
        end
        else
        begin
            retarget_req <= wr_ctrl ? ((dpg_r ^ dpg_new) & dpg_wmask) : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Message interrupt enable
    // ----------------------------------------------------------------
    assign msg_en_vis = msg_en_r && affinity_ns_enable;
    assign message_interrupt_enable = msg_en_vis;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            msg_en_r           <= 1'b0;
            pending_table_load <= 1'b0;
        end
        else
        begin
            pending_table_load <= 1'b0;
            // Once set only reset clears it, so a write of 0 is dropped
            if (wr_ctrl && affinity_ns_enable && !msg_en_r
                && reg_req.wdata[`RDC_BIT_MSG_EN])
            begin
                msg_en_r           <= 1'b1;
                pending_table_load <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register write pending flag
    // ----------------------------------------------------------------
    // New work wins over a completion seen in the same cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rwp_r <= 1'b0;
        end
        else if ((wr_ctrl && |dpg_wmask) || private_enable_clear_write)
        begin
            rwp_r <= 1'b1;
        end
        else if (propagate_done)
        begin
            rwp_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Message pending clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            msg_clear_valid <= 1'b0;
            msg_clear_id    <= 16'h0000;
        end
        else
        begin
            msg_clear_valid <= wr_clear && msg_en_vis
                               && clear_val[63:`RDC_ID_BITS] == '0
                               && msg_query_id >= `RDC_ID_FIRST_MSG
                               && msg_query_pending;
            if (wr_clear)
            begin
                msg_clear_id <= msg_query_id;
            end
        end
    end

    // ----------------------------------------------------------------
    // Private active clear
    // ----------------------------------------------------------------
    always_comb
    begin
        active_view = 32'h00000000;
        for (int i = 0; i < 32; i++)
        begin
            // Bits 15:0 software generated, 31:16 private peripheral
            if (private_secure_mask[i] && !single_security_state_setting)
            begin
                active_view[i] = reg_req.secure && affinity_s_enable
                                 && private_active[i];
            end
            else
            begin
                active_view[i] = (single_security_state_setting ? affinity_ns_enable
                                  : (private_secure_mask[i] ? affinity_s_enable
                                     : affinity_ns_enable))
                                 && private_active[i];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            private_deactivate <= 32'h00000000;
        end
        else
        begin
            // Zero bits and already inactive interrupts have no effect
            private_deactivate <= wr_active ? (reg_req.wdata[31:0] & active_view)
                                            : 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // One-of-N selection
    // ----------------------------------------------------------------
    // While asleep with wake-on-group1 set, this design chooses not to be picked
    always_comb
    begin
        for (int g = 0; g < 3; g++)
        begin
            selectable[g] = !sel_in.processor_sleep_flag
                            && !dpg_vis[g] && sel_in.grp_enable[g];
        end
    end

    // ----------------------------------------------------------------
    // Read path, one cycle after the request
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_ack   <= 1'b0;
            reg_rdata <= 32'h00000000;
        end
        else
        begin
            reg_ack   <= reg_valid;
            reg_rdata <= 32'h00000000;
            if (reg_valid && !reg_req.write)
            begin
                unique case (reg_req.addr)
                    `RDC_OFF_CONTROL:
                    begin
                        reg_rdata[`RDC_BIT_UWP]    <= upstream_busy;
                        reg_rdata[`RDC_BIT_SECURE_GRP1_SELECT_DISABLE]  <= dpg_vis[2]
                            && reg_req.secure;
                        reg_rdata[`RDC_BIT_NONSECURE_GRP1_SELECT_DISABLE] <= dpg_vis[1];
                        reg_rdata[`RDC_BIT_GRP0_SELECT_DISABLE]   <= dpg_vis[0]
                            && (single_security_state_setting || reg_req.secure);
                        reg_rdata[`RDC_BIT_RWP]    <= rwp_r;
                        reg_rdata[`RDC_BIT_MSG_EN] <= msg_en_vis;
                    end
                    `RDC_OFF_ACTIVE_CLEAR:
                    begin
                        reg_rdata <= active_view;
                    end
                    default:
                    begin
                        // Pending clear and unmapped addresses read zero
                        reg_rdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

endmodule : rdc_ctrl
`default_nettype wire

/* File: verilog/rdc_defs.svh */
// Offsets, field positions, reset values and limits of the redistributor control block
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH

// ----------------------------------------------------------------
// Register addresses (bit 16 selects the private-interrupt frame)
// ----------------------------------------------------------------
`define RDC_ADDR_W            17
`define RDC_OFF_CONTROL       17'h00000
`define RDC_OFF_MSG_CLEAR     17'h00048
`define RDC_OFF_MSG_CLEAR_HI  17'h0004c
`define RDC_OFF_ACTIVE_CLEAR  17'h10380

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define RDC_BIT_UWP           31
`define RDC_BIT_SECURE_GRP1_SELECT_DISABLE         26
`define RDC_BIT_NONSECURE_GRP1_SELECT_DISABLE        25
`define RDC_BIT_GRP0_SELECT_DISABLE          24
`define RDC_BIT_RWP           3
`define RDC_BIT_MSG_EN        0
`define RDC_CTRL_RESET        3'h0

// ----------------------------------------------------------------
// Message interrupt identifiers
// ----------------------------------------------------------------
`define RDC_ID_BITS           16
`define RDC_ID_FIRST_MSG      16'h2000

`endif

/* File: verilog/rdc_pkg.sv */
// Types shared by the redistributor control block
`default_nettype none
package rdc_pkg;

    // ----------------------------------------------------------------
    // Register access request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        write;
        logic        secure;
        logic        size64;
        logic [16:0] addr;
        logic [63:0] wdata;
    } rdc_req_t;

    // ----------------------------------------------------------------
    // Per-group selection inputs, index 0 group 0, 1 ns group 1, 2 s group 1
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] grp_enable;
        logic       processor_sleep_flag;
        logic       wake_on_group1_setting;
    } rdc_sel_in_t;

endpackage : rdc_pkg
`default_nettype wire
